// [fpe_editor.sv]
// Purpose: Front panel menu walker and numeric setting editor
// Assumes: Keys are synchronous levels; measured value arrives for the shown index
// Notes:   Limits repeat per message position; one edit at a time
`timescale 1ns/1ps
`default_nettype none
module fpe_editor #(
   parameter int N_MPG = 4,
   parameter int N_SPG = 2,
   parameter int N_SUB = 2,
   parameter int N_MSG = 4,
   parameter int N_HELP = 3,
   parameter int FLASH_CYC = fpe_pkg::FLASH_CYC,
   parameter int HELP_CYC = fpe_pkg::HELP_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire fpe_pkg::fpe_keys_t keys_i,
   input wire logic access_jumper_i,
   input wire logic [fpe_pkg::VAL_W-1:0] meas_value_i,
   output fpe_pkg::fpe_disp_t disp_o
);
   localparam int N_SET = N_SPG * N_SUB * N_MSG;
   localparam int VW = fpe_pkg::VAL_W;
   localparam int EW = fpe_pkg::ENT_W;
   localparam int IW = fpe_pkg::IDX_W;
   localparam int TW = fpe_pkg::TMR_W;

   typedef struct packed {
      fpe_pkg::fpe_mode_t mode;
      logic set_view;
      logic shown;
      logic [1:0] level;
      logic [IW-1:0] page;
      logic [IW-1:0] sub;
      logic [IW-1:0] msg;
      logic [IW-1:0] help;
      fpe_pkg::fpe_flash_t flash;
      logic typing;
      logic dp;
      logic [1:0] frac;
      logic [EW-1:0] ent;
      logic [VW-1:0] val;
      logic [TW-1:0] tmr;
      logic [N_SET-1:0][VW-1:0] store;
      fpe_pkg::fpe_disp_t disp;
   } fpe_st_t;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [EW-1:0] lim_f(input logic [1:0] sel, input logic [1:0] li);
      case (sel)
         2'h0: lim_f = EW'(fpe_pkg::LIM_MIN[li]);
         2'h1: lim_f = EW'(fpe_pkg::LIM_MAX[li]);
         default: lim_f = EW'(fpe_pkg::LIM_STEP[li]);
      endcase
   endfunction

   // Entry scaled to hundredths
   function automatic logic [EW-1:0] scale_f(input logic [EW-1:0] e, input logic [1:0] fr);
      case (fr)
         2'h0: scale_f = EW'(e * 100);
         2'h1: scale_f = EW'(e * 10);
         default: scale_f = e;
      endcase
   endfunction

   // Nearest step above the minimum
   function automatic logic [EW-1:0] round_f(input logic [EW-1:0] v, input logic [1:0] li);
      logic [EW-1:0] mn;
      logic [EW-1:0] st;
      logic [EW-1:0] q;
      mn = lim_f(2'h0, li);
      st = lim_f(2'h2, li);
      q = (v - mn + (st >> 1)) / st;
      round_f = (v <= mn) ? mn : EW'(mn + q * st);
   endfunction

   function automatic logic ok_f(input logic [EW-1:0] v, input logic [1:0] li);
      ok_f = (v >= lim_f(2'h0, li)) && (v <= lim_f(2'h1, li));
   endfunction

   function automatic logic [IW-1:0] wrap_f(input logic [IW-1:0] i, input int cnt, input logic fwd);
      if (fwd) begin
         wrap_f = (int'(i) >= cnt - 1) ? '0 : IW'(i + 1'b1);
      end else begin
         wrap_f = (i == '0) ? IW'(cnt - 1) : IW'(i - 1'b1);
      end
   endfunction

   function automatic logic [3:0] dig_f(input logic [9:0] d);
      dig_f = 4'h0;
      for (int k = 9; k >= 0; k--) begin
         if (d[k]) begin
            dig_f = 4'(k);
         end
      end
   endfunction

   function automatic int idx_f(input logic [IW-1:0] p, input logic [IW-1:0] sb, input logic [IW-1:0] m);
      idx_f = (int'(p) * N_SUB + int'(sb)) * N_MSG + int'(m);
   endfunction

   function automatic fpe_st_t rst_f();
      fpe_st_t r;
      r = '0;
      for (int k = 0; k < N_SET; k++) begin
         r.store[k] = fpe_pkg::LIM_DEF[(k % N_MSG) % fpe_pkg::LIM_N];
      end
      rst_f = r;
   endfunction

   localparam fpe_st_t ST_RST = rst_f();

   fpe_st_t s_ff;
   fpe_st_t nxt_s;
   fpe_pkg::fpe_keys_t kp;
   logic [6:0] navk;
   logic nav_key;
   logic edit_key;
   logic on_set;
   logic edit_now;
   logic [1:0] li;
   int cur;
   logic e_typing;
   logic e_dp;
   logic [1:0] e_frac;
   logic [EW-1:0] e_ent;
   logic [EW-1:0] cand;
   logic [EW-1:0] mn;
   logic [EW-1:0] mx;
   logic [EW-1:0] st;

   fpe_keys u_keys (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .keys_i(keys_i),
      .press_o(kp)
   );

   // -----------------------------------------------------------------
   // Key classes and current setting
   // -----------------------------------------------------------------
   assign navk = {kp.meas, kp.sett, kp.up, kp.dn, kp.enter, kp.esc, kp.help};
   assign nav_key = |navk;
   assign edit_key = kp.vup | kp.vdn | kp.dp | (|kp.digit);
   assign on_set = s_ff.set_view && (s_ff.level == fpe_pkg::LVL_MSG);
   assign edit_now = (s_ff.mode == fpe_pkg::MD_EDIT) || (s_ff.mode == fpe_pkg::MD_NAV && on_set && !nav_key && edit_key);
   assign li = s_ff.msg[1:0];
   assign cur = idx_f(s_ff.page, s_ff.sub, s_ff.msg);
   assign mn = lim_f(2'h0, li);
   assign mx = lim_f(2'h1, li);
   assign st = lim_f(2'h2, li);
   // Fresh edit starts from the stored value, not a stale entry
   assign e_typing = (s_ff.mode == fpe_pkg::MD_EDIT) && s_ff.typing;
   assign cand = e_typing ? round_f(scale_f(s_ff.ent, s_ff.frac), li)
                          : ((s_ff.mode == fpe_pkg::MD_EDIT) ? EW'(s_ff.val) : EW'(s_ff.store[cur]));

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      e_dp = e_typing && s_ff.dp;
      e_frac = e_typing ? s_ff.frac : 2'h0;
      e_ent = e_typing ? s_ff.ent : '0;
      case (s_ff.mode)
         fpe_pkg::MD_NAV: begin
            if (kp.meas) begin
               // Reset image is no header yet, so the first press lands on page 0
               nxt_s.shown = 1'b1;
               if (!s_ff.shown || s_ff.set_view || s_ff.level != fpe_pkg::LVL_PAGE) begin
                  nxt_s.page = '0;
               end else begin
                  nxt_s.page = wrap_f(s_ff.page, N_MPG, 1'b1);
               end
               nxt_s.set_view = 1'b0;
               nxt_s.level = fpe_pkg::LVL_PAGE;
            end else if (kp.sett) begin
               if (!s_ff.set_view || s_ff.level != fpe_pkg::LVL_PAGE) begin
                  nxt_s.page = '0;
               end else begin
                  nxt_s.page = wrap_f(s_ff.page, N_SPG, 1'b1);
               end
               nxt_s.set_view = 1'b1;
               nxt_s.level = fpe_pkg::LVL_PAGE;
            end else if (kp.up || kp.dn) begin
               if (s_ff.level == fpe_pkg::LVL_SUB) begin
                  nxt_s.sub = wrap_f(s_ff.sub, N_SUB, kp.dn);
               end else if (s_ff.level == fpe_pkg::LVL_MSG) begin
                  nxt_s.msg = wrap_f(s_ff.msg, N_MSG, kp.dn);
               end
            end else if (kp.enter) begin
               if (s_ff.level == fpe_pkg::LVL_PAGE) begin
                  nxt_s.level = fpe_pkg::LVL_SUB;
                  nxt_s.sub = '0;
               end else if (s_ff.level == fpe_pkg::LVL_SUB) begin
                  nxt_s.level = fpe_pkg::LVL_MSG;
                  nxt_s.msg = '0;
               end
            end else if (kp.esc) begin
               if (s_ff.level != fpe_pkg::LVL_PAGE) begin
                  nxt_s.level = s_ff.level - 2'h1;
               end
            end else if (kp.help && on_set) begin
               nxt_s.mode = fpe_pkg::MD_HELP;
               nxt_s.help = '0;
               nxt_s.tmr = TW'(HELP_CYC - 1);
            end
         end
         fpe_pkg::MD_FLASH: begin
            // Keys are ignored while a flash message stands
            if (s_ff.tmr == '0) begin
               nxt_s.mode = fpe_pkg::MD_NAV;
               nxt_s.flash = fpe_pkg::FL_NONE;
            end else begin
               nxt_s.tmr = s_ff.tmr - 1'b1;
            end
         end
         fpe_pkg::MD_HELP: begin
            if (kp.esc) begin
               nxt_s.mode = fpe_pkg::MD_NAV;
            end else if (s_ff.tmr == '0) begin
               if (int'(s_ff.help) >= N_HELP - 1) begin
                  nxt_s.mode = fpe_pkg::MD_NAV;
               end else begin
                  nxt_s.help = s_ff.help + 1'b1;
                  nxt_s.tmr = TW'(HELP_CYC - 1);
               end
            end else begin
               nxt_s.tmr = s_ff.tmr - 1'b1;
            end
         end
         default: begin
         end
      endcase

      // Edit actions act on the shown value only, priority esc, enter, step, entry
      if (edit_now) begin
         nxt_s.mode = fpe_pkg::MD_EDIT;
         nxt_s.val = VW'(cand);
         nxt_s.typing = e_typing;
         if (kp.esc) begin
            nxt_s.mode = fpe_pkg::MD_NAV;
            nxt_s.typing = 1'b0;
         end else if (kp.enter) begin
            nxt_s.mode = fpe_pkg::MD_FLASH;
            nxt_s.typing = 1'b0;
            nxt_s.tmr = TW'(FLASH_CYC - 1);
            if (!access_jumper_i) begin
               nxt_s.flash = fpe_pkg::FL_NO_ACCESS;
            end else if (!ok_f(cand, li)) begin
               nxt_s.flash = fpe_pkg::FL_RANGE;
            end else begin
               nxt_s.store[cur] = VW'(cand);
               nxt_s.flash = fpe_pkg::FL_STORED;
            end
         end else if (kp.vup) begin
            nxt_s.typing = 1'b0;
            nxt_s.val = (cand >= mx) ? VW'(mn) : ((cand + st > mx) ? VW'(mx) : VW'(cand + st));
         end else if (kp.vdn) begin
            nxt_s.typing = 1'b0;
            nxt_s.val = (cand <= mn) ? VW'(mx) : ((cand < mn + st) ? VW'(mn) : VW'(cand - st));
            // A typed entry above the maximum stops at the maximum, never outside the limits
            if (cand > mx) begin
               nxt_s.val = VW'(mx);
            end
         end else if (kp.dp) begin
            nxt_s.typing = 1'b1;
            nxt_s.dp = 1'b1;
            nxt_s.frac = e_frac;
            nxt_s.ent = e_ent;
         end else if (|kp.digit) begin
            nxt_s.typing = 1'b1;
            nxt_s.dp = e_dp;
            nxt_s.frac = e_frac;
            nxt_s.ent = e_ent;
            // Digits past the hundredths or beyond five places are dropped
            if ((!e_dp && e_ent <= fpe_pkg::DIG_LIM) || (e_dp && e_frac < fpe_pkg::FRAC_MAX)) begin
               nxt_s.ent = EW'(e_ent * 10 + EW'(dig_f(kp.digit)));
               nxt_s.frac = e_dp ? e_frac + 2'h1 : e_frac;
            end
         end
      end

      // Display image, registered with the state
      nxt_s.disp.set_view = nxt_s.set_view;
      nxt_s.disp.level = nxt_s.level;
      nxt_s.disp.page = nxt_s.page;
      nxt_s.disp.sub = nxt_s.sub;
      nxt_s.disp.msg = nxt_s.msg;
      nxt_s.disp.help = nxt_s.help;
      nxt_s.disp.flash = nxt_s.flash;
      nxt_s.disp.editing = (nxt_s.mode == fpe_pkg::MD_EDIT);
      nxt_s.disp.heading = (nxt_s.level != fpe_pkg::LVL_MSG);
      nxt_s.disp.colon = (nxt_s.level == fpe_pkg::LVL_MSG) &&
                         (nxt_s.mode == fpe_pkg::MD_NAV || nxt_s.mode == fpe_pkg::MD_EDIT);
      case (nxt_s.mode)
         fpe_pkg::MD_FLASH: nxt_s.disp.kind = (nxt_s.flash == fpe_pkg::FL_STORED) ? fpe_pkg::MSG_FLASH
                                                                                  : fpe_pkg::MSG_DIAG;
         fpe_pkg::MD_HELP: nxt_s.disp.kind = fpe_pkg::MSG_HELP;
         default: nxt_s.disp.kind = nxt_s.set_view ? fpe_pkg::MSG_SETTING : fpe_pkg::MSG_MEASURED;
      endcase
      if (nxt_s.mode == fpe_pkg::MD_EDIT) begin
         nxt_s.disp.value = nxt_s.typing ? VW'(scale_f(nxt_s.ent, nxt_s.frac)) : nxt_s.val;
      end else if (nxt_s.set_view) begin
         nxt_s.disp.value = nxt_s.store[idx_f(nxt_s.page, nxt_s.sub, nxt_s.msg)];
      end else begin
         nxt_s.disp.value = meas_value_i;
      end
   end

   // State register, frozen while ce_i is low
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_ff <= ST_RST;
      end else if (ce_i) begin
         s_ff <= nxt_s;
      end
   end

   assign disp_o = s_ff.disp;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence nav_s;
      ce_i && s_ff.mode == fpe_pkg::MD_NAV;
   endsequence
   sequence commit_s;
      ce_i && edit_now && kp.enter && !kp.esc && access_jumper_i && ok_f(cand, li);
   endsequence
   sequence flash_end_s;
      ce_i && s_ff.mode == fpe_pkg::MD_FLASH && s_ff.tmr == '0;
   endsequence

   help_kind_a: assert property (s_ff.disp.kind == fpe_pkg::MSG_HELP |-> s_ff.mode == fpe_pkg::MD_HELP)
      else $error("help message outside help mode");
   meas_first_a: assert property (nav_s ##0 (kp.meas && s_ff.set_view) |=>
      s_ff.page == '0 && s_ff.level == fpe_pkg::LVL_PAGE && !s_ff.set_view)
      else $error("measured key did not show first page");
   sett_cycle_a: assert property (nav_s ##0 (kp.sett && !kp.meas && s_ff.set_view &&
      s_ff.level == fpe_pkg::LVL_PAGE && int'(s_ff.page) == N_SPG - 1) |=> s_ff.page == '0)
      else $error("settings pages did not wrap");
   enter_desc_a: assert property (nav_s ##0 ($onehot(navk) && kp.enter && s_ff.level == fpe_pkg::LVL_SUB) |=>
      s_ff.level == fpe_pkg::LVL_MSG && s_ff.msg == '0)
      else $error("enter did not descend");
   esc_climb_a: assert property (nav_s ##0 ($onehot(navk) && kp.esc && s_ff.level != fpe_pkg::LVL_PAGE) |=>
      s_ff.level == $past(s_ff.level) - 2'h1)
      else $error("escape did not climb one level");
   colon_view_a: assert property (s_ff.disp.colon |-> s_ff.disp.level == fpe_pkg::LVL_MSG &&
      (s_ff.disp.kind == fpe_pkg::MSG_SETTING || s_ff.disp.kind == fpe_pkg::MSG_MEASURED))
      else $error("colon on a non value message");
   jumper_gate_a: assert property (ce_i && edit_now && kp.enter && !kp.esc && !access_jumper_i |=>
      s_ff.flash == fpe_pkg::FL_NO_ACCESS && s_ff.disp.kind == fpe_pkg::MSG_DIAG && $stable(s_ff.store))
      else $error("store accepted without access jumper");
   help_start_a: assert property (nav_s ##0 ($onehot(navk) && kp.help && on_set) |=>
      s_ff.mode == fpe_pkg::MD_HELP && s_ff.help == '0)
      else $error("help did not start");
   edit_range_a: assert property (s_ff.mode == fpe_pkg::MD_EDIT && !s_ff.typing |->
      ok_f(EW'(s_ff.val), li))
      else $error("edited value out of limits");
   digit_shift_a: assert property (ce_i && s_ff.mode == fpe_pkg::MD_EDIT && s_ff.typing && !s_ff.dp &&
      !nav_key && !kp.vup && !kp.vdn && !kp.dp && $onehot(kp.digit) && s_ff.ent <= fpe_pkg::DIG_LIM |=>
      s_ff.ent == EW'($past(s_ff.ent) * 10 + EW'(dig_f($past(kp.digit)))))
      else $error("digit not appended on the right");
   esc_drop_a: assert property (ce_i && edit_now && kp.esc |=>
      s_ff.mode == fpe_pkg::MD_NAV && $stable(s_ff.store) && s_ff.disp.value == s_ff.store[cur])
      else $error("escape did not restore stored value");
   wrap_up_a: assert property (ce_i && edit_now && !nav_key && kp.vup && cand == mx |=>
      EW'(s_ff.val) == $past(mn))
      else $error("step up did not wrap to minimum");
   wrap_dn_a: assert property (ce_i && s_ff.mode == fpe_pkg::MD_EDIT && !s_ff.typing && !nav_key &&
      !kp.vup && kp.vdn && EW'(s_ff.val) == mn |=> EW'(s_ff.val) == $past(mx))
      else $error("step down did not wrap to maximum");
   store_hold_a: assert property (!(ce_i && edit_now && kp.enter) |=> $stable(s_ff.store))
      else $error("setting changed without enter");
   commit_flash_a: assert property (commit_s |=> s_ff.mode == fpe_pkg::MD_FLASH &&
      s_ff.disp.kind == fpe_pkg::MSG_FLASH && s_ff.flash == fpe_pkg::FL_STORED)
      else $error("no confirmation after store");
   flash_back_a: assert property (flash_end_s |=> s_ff.mode == fpe_pkg::MD_NAV && s_ff.flash == fpe_pkg::FL_NONE)
      else $error("flash did not end");
   round_store_a: assert property (commit_s |=> EW'(s_ff.store[$past(cur)]) == $past(cand) &&
      (($past(cand) - $past(mn)) % $past(st)) == '0)
      else $error("stored value not on a step");
endmodule
`default_nettype wire

// [fpe_pkg.sv]
// Purpose: Shared constants and types for the front panel setting editor
// Assumes: Values are fixed point in hundredths of a unit
// Notes:   Limit tables are indexed by message position inside a sub-page
package fpe_pkg;
   // -----------------------------------------------------------------
   // Widths and timing
   // -----------------------------------------------------------------
   localparam int VAL_W = 16;
   localparam int ENT_W = 24;
   localparam int IDX_W = 3;
   localparam int TMR_W = 26;
   localparam int LIM_N = 4;
   localparam int CLK_HZ = 20_000_000;
   localparam int FLASH_MS = 1500;
   localparam int HELP_MS = 2000;
   localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
   localparam int HELP_CYC = HELP_MS * (CLK_HZ / 1000);
   localparam logic [1:0] FRAC_MAX = 2'h2;
   localparam logic [ENT_W-1:0] DIG_LIM = 24'h00270f; // 9999, keeps the whole part of an entry at or below 99999
   localparam logic [1:0] LVL_PAGE = 2'h0;
   localparam logic [1:0] LVL_SUB = 2'h1;
   localparam logic [1:0] LVL_MSG = 2'h2;

   // -----------------------------------------------------------------
   // Numeric setting limits, hundredths
   // -----------------------------------------------------------------
   localparam logic [VAL_W-1:0] LIM_MIN [LIM_N] = '{16'h1388, 16'h0005, 16'h0000, 16'h0064};
   localparam logic [VAL_W-1:0] LIM_MAX [LIM_N] = '{16'h5dc0, 16'h07d0, 16'hea60, 16'h03e8};
   localparam logic [VAL_W-1:0] LIM_STEP [LIM_N] = '{16'h000a, 16'h0001, 16'h0064, 16'h0032};
   localparam logic [VAL_W-1:0] LIM_DEF [LIM_N] = '{16'h2ee0, 16'h0064, 16'h0000, 16'h0064};

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic meas;
      logic sett;
      logic up;
      logic dn;
      logic enter;
      logic esc;
      logic help;
      logic vup;
      logic vdn;
      logic dp;
      logic [9:0] digit;
   } fpe_keys_t;

   typedef enum logic [2:0] {MSG_MEASURED, MSG_SETTING, MSG_DIAG, MSG_FLASH, MSG_HELP} fpe_msg_t;
   typedef enum logic [1:0] {FL_NONE, FL_STORED, FL_NO_ACCESS, FL_RANGE} fpe_flash_t;
   typedef enum logic [1:0] {MD_NAV, MD_EDIT, MD_FLASH, MD_HELP} fpe_mode_t;

   typedef struct packed {
      fpe_msg_t kind;
      logic set_view;
      logic heading;
      logic colon;
      logic [1:0] level;
      logic [IDX_W-1:0] page;
      logic [IDX_W-1:0] sub;
      logic [IDX_W-1:0] msg;
      logic [IDX_W-1:0] help;
      fpe_flash_t flash;
      logic editing;
      logic [VAL_W-1:0] value;
   } fpe_disp_t;
endpackage

// [fpe_keys.sv]
// Purpose: Turns held keypad levels into single-cycle press events
// Assumes: Key levels are already clean and synchronous to sys_clk_i
// Notes:   A held key yields one event; release and press again for another
`timescale 1ns/1ps
`default_nettype none
module fpe_keys (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire fpe_pkg::fpe_keys_t keys_i,
   output fpe_pkg::fpe_keys_t press_o
);
   typedef struct packed {
      fpe_pkg::fpe_keys_t prev;
      fpe_pkg::fpe_keys_t pulse;
   } fpe_kst_t;

   fpe_kst_t s_ff;
   fpe_kst_t nxt_s;

   // -----------------------------------------------------------------
   // Rising edge per key
   // -----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.prev = keys_i;
      nxt_s.pulse = keys_i & ~s_ff.prev;
   end

   // State register, frozen while ce_i is low
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_ff <= '0;
      end else if (ce_i) begin
         s_ff <= nxt_s;
      end
   end

   assign press_o = s_ff.pulse;

   // Two consecutive events of the same key are impossible
   single_event_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ce_i |=> (s_ff.pulse & $past(s_ff.pulse)) == '0)
      else $error("key event lasted more than one cycle");
endmodule
`default_nettype wire

// [fpe_keypad.sv]
// Purpose: Keypad model, one key at a time
// Assumes: Levels move on the falling clock edge
// Notes:   Release after each press so the edge detector rearms
`timescale 1ns/1ps
`default_nettype none
module fpe_keypad (
   input wire logic sys_clk_i,
   output fpe_pkg::fpe_keys_t keys_o
);
   // ---------------------------------------------
   // Press then release
   // ---------------------------------------------
   initial begin
      keys_o = '0;
   end
   // Two quiet edges after release cover the answer
   task automatic press(input int k);
      @(negedge sys_clk_i);
      keys_o = fpe_pkg::fpe_keys_t'(20'h1 << k);
      @(negedge sys_clk_i);
      keys_o = '0;
      repeat (2) @(negedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// [fpe_editor_bench.sv]
// Purpose: Self-checking bench for the setting editor
// Assumes: Short flash and help times
// Notes:   Settings view, message 0 limits
`timescale 1ns/1ps
`default_nettype none
module fpe_editor_bench;
   localparam int FC = 8;
   localparam int HC = 12;
   localparam int KM = 19, KS = 18, KU = 17, KD = 16, KE = 15, KX = 14, KH = 13, KV = 12, KW = 11, KP = 10;
   logic sys_clk_i;
   logic reset_n_i;
   logic jumper;
   fpe_pkg::fpe_keys_t keys;
   fpe_pkg::fpe_disp_t disp;
   int fails;
   int samples_checked;
   fpe_keypad pad (.sys_clk_i(sys_clk_i), .keys_o(keys));
   fpe_editor #(.FLASH_CYC(FC), .HELP_CYC(HC)) dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .ce_i(1'b1), .keys_i(keys), .access_jumper_i(jumper), .meas_value_i(16'h1234), .disp_o(disp));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic seq(input int ks[]);
      foreach (ks[i]) pad.press(ks[i]);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d fails=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_nav;
      seq('{KM, KM});
      chk(disp.page, 3'h1);
      seq('{KS, KS, KS});
      chk({disp.set_view, disp.page}, 4'h8);
      seq('{KE, KD, KD});
      chk({disp.level, disp.sub}, 5'h08);
      seq('{KE, KD, KU});
      chk({disp.level, disp.msg}, 5'h10);
      chk({disp.kind, disp.colon}, {fpe_pkg::MSG_SETTING, 1'b1});
      chk(disp.heading, 1'b0);
      seq('{KX});
      chk(disp.level, 2'h1);
      chk(disp.heading, 1'b1);
      seq('{KE});
      chk(disp.value, 16'h2ee0);
   endtask
   // Typed 69.28 rounds to the 0.10 step
   task automatic t_type;
      seq('{6, 9, KP, 2, 8});
      chk({disp.editing, disp.value}, 17'h11b10);
      seq('{KE});
      chk({disp.kind, disp.flash}, {fpe_pkg::MSG_FLASH, fpe_pkg::FL_STORED});
      repeat (FC + 2) @(negedge sys_clk_i);
      chk({disp.kind, disp.value}, {fpe_pkg::MSG_SETTING, 16'h1b12});
   endtask
   task automatic t_step;
      seq('{KW});
      chk(disp.value, 16'h1b08);
      seq('{KX});
      chk({disp.editing, disp.value}, 17'h01b12);
      seq('{2, 4, 0, KV});
      chk(disp.value, 16'h1388);
      seq('{KW});
      chk(disp.value, 16'h5dc0);
      seq('{KX});
   endtask
   task automatic t_lock;
      jumper = 1'b0;
      seq('{KV, KE});
      chk({disp.kind, disp.flash}, {fpe_pkg::MSG_DIAG, fpe_pkg::FL_NO_ACCESS});
      repeat (FC + 2) @(negedge sys_clk_i);
      chk(disp.value, 16'h1b12);
      // Typed 300.00 lies above the maximum and is refused
      jumper = 1'b1;
      seq('{3, 0, 0, KE});
      chk({disp.kind, disp.flash}, {fpe_pkg::MSG_DIAG, fpe_pkg::FL_RANGE});
      repeat (FC + 2) @(negedge sys_clk_i);
      chk(disp.value, 16'h1b12);
   endtask
   task automatic t_help;
      seq('{KH});
      chk({disp.kind, disp.help}, {fpe_pkg::MSG_HELP, 3'h0});
      repeat (HC + 2) @(negedge sys_clk_i);
      chk(disp.help, 3'h1);
      seq('{KX, KM});
      chk({disp.kind, disp.value}, {fpe_pkg::MSG_MEASURED, 16'h1234});
   endtask
   // ---------------------------------------------
   // Clock, reset, sequence and watchdog
   // ---------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      fails = 0;
      samples_checked = 0;
      jumper = 1'b1;
      reset_n_i = 1'b0;
      repeat (5) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      t_nav();
      t_type();
      t_step();
      t_lock();
      t_help();
      tally_and_finish();
   end
   // About 200 cycles expected
   initial begin
      #(5000 * 50);
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
